// *** hw/bdr_map.svh ***
// register offsets, field positions and reset values of the diagnostic readback bank
`ifndef BDR_MAP_SVH
`define BDR_MAP_SVH
`define BDR_ADDR_W          8
`define BDR_OFF_INPUT_DUTY  8'h16
`define BDR_OFF_OUTPUT_DUTY 8'h18
`define BDR_OFF_SINK_CODE   8'h1A
`define BDR_OFF_BOOST_CODE  8'h1C
`define BDR_OFF_STRAP       8'h1E
`define BDR_RESET_VALUE     16'h0000
`define BDR_SINK_CODE_W     12
`define BDR_BOOST_CODE_W    11
`define BDR_PWM_FREQ_LSB    12
`define BDR_GROUPING_LSB    8
`define BDR_BOOST_FREQ_LSB  3
`define BDR_MODE_LSB        0
`define BDR_ADDR_SEL_BIT    2
`define BDR_BUS_ADDR_LOW    7'h2B
`define BDR_BUS_ADDR_HIGH   7'h2A
`endif

// *** hw/bdr_pkg.sv ***
// types of the diagnostic readback bank
`default_nettype none
package bdr_pkg;
    typedef enum logic [1:0] {
        BDR_DIM_DUTY,
        BDR_DIM_HYBRID,
        BDR_DIM_CONST_CURRENT,
        BDR_DIM_DIRECT
    } bdr_dim_method_t;

    // strap detection results, one 3-bit code each
    typedef struct packed {
        logic [2:0] pwm_freq;
        logic [2:0] grouping;
        logic [2:0] boost_freq;
        logic [2:0] mode;
    } bdr_strap_t;

    // live values from the dimming and boost logic
    typedef struct packed {
        logic [15:0] input_duty;
        logic [15:0] output_duty;
        logic [11:0] sink_code;
        logic [10:0] boost_code;
    } bdr_live_t;
endpackage
`default_nettype wire

// *** hw/bdr_readback.sv ***
// read-only diagnostic register bank of the backlight driver
`timescale 1ns/1ps
`default_nettype none
`include "bdr_map.svh"

module bdr_readback #(
    parameter int ADDR_W = `BDR_ADDR_W
) (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    clk_en,
    input  wire logic                    live_valid,
    input  wire bdr_pkg::bdr_live_t      live_in,
    input  wire logic                    strap_valid,
    input  wire bdr_pkg::bdr_strap_t     strap_in,
    input  wire logic                    rd_en,
    input  wire logic                    wr_en,
    input  wire logic [ADDR_W-1:0]       addr,
    input  wire logic [15:0]             wr_data,
    output logic      [15:0]             rd_data,
    output logic                         rd_valid,
    output logic      [6:0]              bus_address,
    output var bdr_pkg::bdr_dim_method_t dim_method
);
    import bdr_pkg::*;

    // refuse an address width that cannot hold the highest offset
    if (ADDR_W < 5) begin
        $error("ADDR_W too narrow for the register offsets");
    end

    // held images of the five registers
    logic [15:0]     in_duty_q, in_duty_d;
    logic [15:0]     out_duty_q, out_duty_d;
    logic [11:0]     sink_q, sink_d;
    logic [10:0]     boost_q, boost_d;
    bdr_strap_t      strap_q, strap_d;
    logic [15:0]     rd_data_d;
    logic            rd_valid_d;
    logic [6:0]      bus_addr_d;
    bdr_dim_method_t dim_d;

    // place strap fields, reserved bits zero
    function automatic logic [15:0] pack_strap(input bdr_strap_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[`BDR_PWM_FREQ_LSB +: 3]   = s.pwm_freq;
        w[`BDR_GROUPING_LSB +: 3]   = s.grouping;
        w[`BDR_BOOST_FREQ_LSB +: 3] = s.boost_freq;
        w[`BDR_MODE_LSB +: 3]       = s.mode;
        return w;
    endfunction

    // register read mux; unmapped offsets read zero
    function automatic logic [15:0] read_word(input logic [ADDR_W-1:0] a,
                                              input logic [15:0] i_d,
                                              input logic [15:0] o_d,
                                              input logic [11:0] sc,
                                              input logic [10:0] bc,
                                              input bdr_strap_t st);
        logic [15:0] r;
        r = 16'h0000;
        if (a == ADDR_W'(`BDR_OFF_INPUT_DUTY)) begin
            r = i_d;
        end else if (a == ADDR_W'(`BDR_OFF_OUTPUT_DUTY)) begin
            r = o_d;
        end else if (a == ADDR_W'(`BDR_OFF_SINK_CODE)) begin
            r = {4'h0, sc};
        end else if (a == ADDR_W'(`BDR_OFF_BOOST_CODE)) begin
            r = {5'h00, bc};
        end else if (a == ADDR_W'(`BDR_OFF_STRAP)) begin
            r = pack_strap(st);
        end
        return r;
    endfunction

    // next values: only the internal logic updates, bus writes never do
    always_comb begin
        in_duty_d  = in_duty_q;
        out_duty_d = out_duty_q;
        sink_d     = sink_q;
        boost_d    = boost_q;
        strap_d    = strap_q;
        if (live_valid) begin
            in_duty_d  = live_in.input_duty;
            out_duty_d = live_in.output_duty;
            sink_d     = live_in.sink_code;
            boost_d    = live_in.boost_code;
        end
        if (strap_valid) begin
            strap_d = strap_in;
        end
        // wr_en and wr_data deliberately unused
        rd_valid_d = rd_en;
        rd_data_d  = rd_en ? read_word(addr, in_duty_q, out_duty_q, sink_q, boost_q, strap_q)
                           : 16'h0000;
        bus_addr_d = strap_q.mode[`BDR_ADDR_SEL_BIT - `BDR_MODE_LSB] ? `BDR_BUS_ADDR_HIGH
                                                                      : `BDR_BUS_ADDR_LOW;
        dim_d      = bdr_dim_method_t'(strap_q.mode[1:0]);
    end

    // registers, cleared on reset except bus_address, which loads the low bus address, and frozen while clk_en is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_duty_q   <= `BDR_RESET_VALUE;
            out_duty_q  <= `BDR_RESET_VALUE;
            sink_q      <= 12'h000;
            boost_q     <= 11'h000;
            strap_q     <= '0;
            rd_data     <= 16'h0000;
            rd_valid    <= 1'b0;
            bus_address <= `BDR_BUS_ADDR_LOW;
            dim_method  <= BDR_DIM_DUTY;
        end else if (clk_en) begin
            in_duty_q   <= in_duty_d;
            out_duty_q  <= out_duty_d;
            sink_q      <= sink_d;
            boost_q     <= boost_d;
            strap_q     <= strap_d;
            rd_data     <= rd_data_d;
            rd_valid    <= rd_valid_d;
            bus_address <= bus_addr_d;
            dim_method  <= dim_d;
        end
    end

    // assertions
    property p_input_duty;
        @(posedge clk) disable iff (!nrst)
        (clk_en && live_valid ##1 clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_INPUT_DUTY)
            && !live_valid)
        |=> rd_data == $past(live_in.input_duty, 2);
    endproperty
    a_input_duty: assert property (p_input_duty) else $error("input duty readback wrong");

    property p_output_duty;
        @(posedge clk) disable iff (!nrst)
        (clk_en && live_valid ##1 clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_OUTPUT_DUTY)
            && !live_valid)
        |=> rd_data == $past(live_in.output_duty, 2);
    endproperty
    a_output_duty: assert property (p_output_duty) else $error("output duty readback wrong");

    property p_sink_code;
        @(posedge clk) disable iff (!nrst)
        (clk_en && live_valid ##1 clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_SINK_CODE)
            && !live_valid)
        |=> rd_data == {4'h0, $past(live_in.sink_code, 2)};
    endproperty
    a_sink_code: assert property (p_sink_code) else $error("sink code readback wrong");

    property p_boost_code;
        @(posedge clk) disable iff (!nrst)
        (clk_en && live_valid ##1 clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_BOOST_CODE)
            && !live_valid)
        |=> rd_data == {5'h00, $past(live_in.boost_code, 2)};
    endproperty
    a_boost_code: assert property (p_boost_code) else $error("boost code readback wrong");

    property p_strap_fields;
        @(posedge clk) disable iff (!nrst)
        (clk_en && strap_valid ##1 clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_STRAP)
            && !strap_valid)
        |=> rd_data[14:12] == $past(strap_in.pwm_freq, 2)
            && rd_data[10:8] == $past(strap_in.grouping, 2)
            && rd_data[5:3] == $past(strap_in.boost_freq, 2)
            && rd_data[2:0] == $past(strap_in.mode, 2);
    endproperty
    a_strap_fields: assert property (p_strap_fields) else $error("strap fields wrong");

    property p_reserved_zero;
        @(posedge clk) disable iff (!nrst)
        clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_STRAP)
        |=> rd_data[15] == 1'b0 && rd_data[11] == 1'b0 && rd_data[7:6] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_address_pick;
        @(posedge clk) disable iff (!nrst)
        clk_en |=> bus_address == ($past(strap_q.mode[2]) ? `BDR_BUS_ADDR_HIGH
                                                            : `BDR_BUS_ADDR_LOW);
    endproperty
    a_address_pick: assert property (p_address_pick) else $error("bus address wrong");

    // method follows the two low mode bits one cycle later
    property p_method_pick;
        @(posedge clk) disable iff (!nrst)
        clk_en |=> dim_method == bdr_dim_method_t'($past(strap_q.mode[1:0]));
    endproperty
    a_method_pick: assert property (p_method_pick) else $error("dimming method wrong");

    property p_write_ignored;
        @(posedge clk) disable iff (!nrst)
        clk_en && wr_en && !live_valid && !strap_valid
        |=> in_duty_q == $past(in_duty_q) && strap_q == $past(strap_q) && sink_q == $past(sink_q);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed a register");

    property p_reset_zero;
        @(posedge clk) $rose(nrst) |-> in_duty_q == 16'h0000 && boost_q == 11'h000
            && strap_q == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

    // a taken read answers on the next edge
    property p_rd_valid_pulse;
        @(posedge clk) disable iff (!nrst)
        clk_en && rd_en |=> rd_valid;
    endproperty
    a_rd_valid_pulse: assert property (p_rd_valid_pulse) else $error("read not answered");

    // a write without a read returns nothing
    property p_write_no_answer;
        @(posedge clk) disable iff (!nrst)
        clk_en && wr_en && !rd_en |=> !rd_valid && rd_data == 16'h0000;
    endproperty
    a_write_no_answer: assert property (p_write_no_answer) else $error("stray answer");

    // frozen clock enable holds every output
    property p_freeze_outputs;
        @(posedge clk) disable iff (!nrst)
        !clk_en |=> $stable(rd_data) && $stable(rd_valid) && $stable(bus_address)
            && $stable(dim_method);
    endproperty
    a_freeze_outputs: assert property (p_freeze_outputs) else $error("output moved");

    // frozen clock enable holds every register image
    property p_freeze_state;
        @(posedge clk) disable iff (!nrst)
        !clk_en |=> $stable(in_duty_q) && $stable(out_duty_q) && $stable(sink_q)
            && $stable(boost_q) && $stable(strap_q);
    endproperty
    a_freeze_state: assert property (p_freeze_state) else $error("register moved");

    // writes leave the other live images alone too
    property p_wr_ignored_live;
        @(posedge clk) disable iff (!nrst)
        clk_en && wr_en && !live_valid |=> $stable(out_duty_q) && $stable(boost_q);
    endproperty
    a_wr_ignored_live: assert property (p_wr_ignored_live) else $error("write hit");

    // reserved bits above the sink code read zero
    property p_sink_reserved;
        @(posedge clk) disable iff (!nrst)
        clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_SINK_CODE) |=> rd_data[15:12] == 4'h0;
    endproperty
    a_sink_reserved: assert property (p_sink_reserved) else $error("sink bits set");

    // reserved bits above the boost code read zero
    property p_boost_reserved;
        @(posedge clk) disable iff (!nrst)
        clk_en && rd_en && addr == ADDR_W'(`BDR_OFF_BOOST_CODE) |=> rd_data[15:11] == 5'h00;
    endproperty
    a_boost_reserved: assert property (p_boost_reserved) else $error("boost bits set");

    // a strap strobe latches all four codes
    property p_strap_load;
        @(posedge clk) disable iff (!nrst)
        clk_en && strap_valid |=> strap_q == $past(strap_in);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap not latched");

    // strap codes hold between strobes
    property p_strap_hold;
        @(posedge clk) disable iff (!nrst)
        !strap_valid |=> $stable(strap_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

    // a live strobe latches both codes
    property p_code_load;
        @(posedge clk) disable iff (!nrst)
        clk_en && live_valid |=> sink_q == $past(live_in.sink_code)
            && boost_q == $past(live_in.boost_code);
    endproperty
    a_code_load: assert property (p_code_load) else $error("codes not latched");

    // a live strobe latches both duty values
    property p_duty_load;
        @(posedge clk) disable iff (!nrst)
        clk_en && live_valid |=> in_duty_q == $past(live_in.input_duty)
            && out_duty_q == $past(live_in.output_duty);
    endproperty
    a_duty_load: assert property (p_duty_load) else $error("duties not latched");

    // live values hold between strobes
    property p_live_hold;
        @(posedge clk) disable iff (!nrst)
        !live_valid |=> $stable(in_duty_q) && $stable(out_duty_q) && $stable(sink_q)
            && $stable(boost_q);
    endproperty
    a_live_hold: assert property (p_live_hold) else $error("live value changed");

    // reset leaves the port outputs at their idle values
    property p_reset_outputs;
        @(posedge clk) $rose(nrst) |-> rd_data == 16'h0000 && !rd_valid
            && bus_address == `BDR_BUS_ADDR_LOW && dim_method == BDR_DIM_DUTY
            && out_duty_q == 16'h0000 && sink_q == 12'h000;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle");
endmodule
`default_nettype wire

// *** verification/tb_backlight_diagnostic_readback.sv ***
// self-checking bench of the diagnostic readback bank
`timescale 1ns/1ps
`default_nettype none
`include "bdr_map.svh"
module tb_backlight_diagnostic_readback;
    import bdr_pkg::*;
    logic            clk = 1'b0;
    logic            nrst = 1'b0;
    logic            clk_en = 1'b1;
    logic            live_valid = 1'b0;
    bdr_live_t       live_in = '0;
    logic            strap_valid = 1'b0;
    bdr_strap_t      strap_in = '0;
    logic            rd_en = 1'b0;
    logic            wr_en = 1'b0;
    logic [7:0]      addr = 8'h00;
    logic [15:0]     wr_data = 16'h0000;
    logic [15:0]     rd_data;
    logic            rd_valid;
    logic [6:0]      bus_address;
    bdr_dim_method_t dim_method;
    int              fails = 0;
    int              cmp_count = 0;
    int              cyc = 0;
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    bdr_readback i_bdr_readback (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .live_valid(live_valid),
        .live_in(live_in), .strap_valid(strap_valid), .strap_in(strap_in),
        .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .bus_address(bus_address),
        .dim_method(dim_method));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one read, answer one cycle later
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk) #1;
        rd_en = 1'b0;
        check({15'h0, rd_valid}, 16'h0001);
        check(rd_data, e);
    endtask
    task automatic t_reset;
        rd(`BDR_OFF_INPUT_DUTY, `BDR_RESET_VALUE);
        rd(`BDR_OFF_OUTPUT_DUTY, `BDR_RESET_VALUE);
        rd(`BDR_OFF_SINK_CODE, `BDR_RESET_VALUE);
        rd(`BDR_OFF_BOOST_CODE, `BDR_RESET_VALUE);
        rd(`BDR_OFF_STRAP, `BDR_RESET_VALUE);
        check({9'h0, bus_address}, {9'h0, `BDR_BUS_ADDR_LOW});
        check({14'h0, dim_method}, 16'h0000);
    endtask
    // load live values, then read one offset in the very next cycle
    task automatic live_rd(input bdr_live_t v, input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) #1;
        live_valid = 1'b1;
        live_in = v;
        @(posedge clk) #1;
        live_valid = 1'b0;
        live_in = '0;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk) #1;
        rd_en = 1'b0;
        check({15'h0, rd_valid}, 16'h0001);
        check(rd_data, e);
    endtask
    task automatic t_live;
        bdr_live_t v;
        v = '{16'hA5C3, 16'h3C5A, 12'hFFF, 11'h7FF};
        live_rd(v, `BDR_OFF_INPUT_DUTY, 16'hA5C3);
        live_rd(v, `BDR_OFF_OUTPUT_DUTY, 16'h3C5A);
        live_rd(v, `BDR_OFF_SINK_CODE, 16'h0FFF);
        live_rd(v, `BDR_OFF_BOOST_CODE, 16'h07FF);
    endtask
    // clock enable low: strobes and reads are not taken
    task automatic t_freeze;
        @(posedge clk) #1;
        clk_en = 1'b0;
        live_valid = 1'b1;
        live_in = '{16'h1234, 16'h5678, 12'h9AB, 11'h4CD};
        rd_en = 1'b1;
        addr = `BDR_OFF_OUTPUT_DUTY;
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, rd_valid}, 16'h0000);
        check(rd_data, 16'h0000);
        clk_en = 1'b1;
        live_valid = 1'b0;
        live_in = '0;
        rd_en = 1'b0;
        rd(`BDR_OFF_OUTPUT_DUTY, 16'h3C5A);
    endtask
    task automatic t_strap;
        logic [2:0] c;
        logic [2:0] f;
        logic [2:0] g;
        logic [2:0] b;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            f = ~c;
            g = c + 3'h3;
            b = c ^ 3'h6;
            @(posedge clk) #1;
            strap_valid = 1'b1;
            strap_in = '{f, g, b, c};
            @(posedge clk) #1;
            strap_valid = 1'b0;
            strap_in = ~strap_in;
            rd_en = 1'b1;
            addr = `BDR_OFF_STRAP;
            @(posedge clk) #1;
            rd_en = 1'b0;
            check({15'h0, rd_valid}, 16'h0001);
            check(rd_data, {1'b0, f, 1'b0, g, 2'b00, b, c});
            check({9'h0, bus_address},
                  {9'h0, c[2] ? `BDR_BUS_ADDR_HIGH : `BDR_BUS_ADDR_LOW});
            check({14'h0, dim_method}, {14'h0, c[1:0]});
        end
    endtask
    // reset in mid-run clears every loaded value
    task automatic t_mid_reset;
        @(posedge clk) #1;
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        check({15'h0, rd_valid}, 16'h0000);
        check({9'h0, bus_address}, {9'h0, `BDR_BUS_ADDR_LOW});
        check({14'h0, dim_method}, 16'h0000);
        t_reset();
    endtask
    task automatic t_write;
        @(posedge clk) #1;
        wr_en = 1'b1;
        wr_data = 16'hFFFF;
        addr = `BDR_OFF_STRAP;
        @(posedge clk) #1;
        addr = `BDR_OFF_INPUT_DUTY;
        @(posedge clk) #1;
        wr_en = 1'b0;
        wr_data = 16'h0000;
        check({15'h0, rd_valid}, 16'h0000);
        rd(`BDR_OFF_STRAP, 16'h020F);
        rd(`BDR_OFF_INPUT_DUTY, 16'hA5C3);
        rd(8'h17, 16'h0000);
        rd(8'h20, 16'h0000);
    endtask
    // verdict and end of run
    task automatic results;
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_live();
        t_freeze();
        t_strap();
        t_write();
        t_mid_reset();
        results();
    end
endmodule
`default_nettype wire
